// ==== rtl/synth_cal_pkg.sv ====
`default_nettype none
package synth_cal_pkg;
    // ------------------------------------------------------------
    // clock and calibration step timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    // least dwell per search step, lets the amplitude detector settle
    localparam int unsigned CAL_STEP_NS = 100;
    localparam int unsigned CAL_STEP_RAW = (CAL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CAL_STEP_CYCLES = (CAL_STEP_RAW < 1) ? 1 : CAL_STEP_RAW;
    localparam int unsigned DIV_W = 16;

    // ------------------------------------------------------------
    // bus layout: register indices, byte address is four times these
    // ------------------------------------------------------------
    localparam int unsigned IDX_W = 6;
    localparam int unsigned ADDR_W = IDX_W + 2;
    localparam logic [IDX_W-1:0] IDX_PUMP = 6'h0e;
    localparam logic [IDX_W-1:0] IDX_AMP = 6'h13;
    localparam logic [IDX_W-1:0] IDX_START = 6'h14;
    localparam logic [IDX_W-1:0] IDX_CTRL = 6'h30;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h31;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned REG_W = 16;
    localparam int unsigned PUMP_CUR_W = 5;
    localparam int unsigned GAIN_W = 2;
    localparam int unsigned AMP_W = 9;
    localparam int unsigned PUMP_DN_LSB = 7;
    localparam int unsigned PUMP_UP_LSB = 2;
    localparam int unsigned PUMP_GAIN_LSB = 0;
    localparam int unsigned AMP_CODE_LSB = 3;
    localparam int unsigned START_LSB = 0;
    localparam logic [PUMP_CUR_W-1:0] PUMP_CUR_RST = 5'h03;
    localparam logic [GAIN_W-1:0] GAIN_RST = 2'h1;
    localparam logic [AMP_W-1:0] AMP_CODE_RST = 9'h12c;
    localparam logic [AMP_W-1:0] AMP_CODE_MIN = 9'h0fa;
    localparam logic [AMP_W-1:0] AMP_CODE_MAX = 9'h1c2;
    localparam logic [REG_W-1:0] PUMP_REG_RST = (REG_W'(PUMP_CUR_RST) << PUMP_DN_LSB)
        | (REG_W'(PUMP_CUR_RST) << PUMP_UP_LSB) | (REG_W'(GAIN_RST) << PUMP_GAIN_LSB);
    localparam logic [REG_W-1:0] AMP_REG_RST = REG_W'(AMP_CODE_RST) << AMP_CODE_LSB;
    localparam logic [REG_W-1:0] START_REG_RST = REG_W'(AMP_CODE_MIN) << START_LSB;

    // ------------------------------------------------------------
    // coarse gain codes and their factors in halves
    // ------------------------------------------------------------
    localparam logic [GAIN_W-1:0] GAIN_CODE_X1 = 2'h0;
    localparam logic [GAIN_W-1:0] GAIN_CODE_X2 = 2'h1;
    localparam logic [GAIN_W-1:0] GAIN_CODE_X15 = 2'h2;
    localparam logic [GAIN_W-1:0] GAIN_CODE_X25 = 2'h3;
    localparam logic [2:0] GAIN_X1_HALVES = 3'h2;
    localparam logic [2:0] GAIN_X2_HALVES = 3'h4;
    localparam logic [2:0] GAIN_X15_HALVES = 3'h3;
    localparam logic [2:0] GAIN_X25_HALVES = 3'h5;

    // ------------------------------------------------------------
    // control and status bits
    // ------------------------------------------------------------
    localparam int unsigned CTRL_OVR_BIT = 0;
    localparam int unsigned CTRL_EN_BIT = 1;
    localparam int unsigned CTRL_USE_START_BIT = 2;
    localparam int unsigned CTRL_GO_BIT = 3;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_DONE_BIT = 1;
    localparam int unsigned STAT_AMP_LSB = 4;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'h1,
        CAL_SEARCH = 2'h2
    } cal_state_e;
endpackage : synth_cal_pkg
`default_nettype wire

// ==== rtl/amplitude_cal_search.sv ====
`timescale 1ns/10ps
`default_nettype none
module amplitude_cal_search #(
    parameter int unsigned STEP_CYCLES = synth_cal_pkg::CAL_STEP_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic use_start,
    input wire logic [synth_cal_pkg::AMP_W-1:0] start_value,
    input wire logic at_target,
    output logic busy,
    output logic done,
    output logic [synth_cal_pkg::AMP_W-1:0] code
);
    import synth_cal_pkg::*;

    typedef struct packed {
        cal_state_e state;
        logic [AMP_W-1:0] code;
        logic [DIV_W-1:0] div;
        logic done;
    } cal_s;

    localparam cal_s ST_RST = '{state: CAL_IDLE, code: AMP_CODE_RST, div: '0, done: 1'b0};
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_CYCLES - 1);

    cal_s st_q;
    cal_s st_d;
    logic tick;

    // ------------------------------------------------------------
    // upward search, one code per step
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        tick = (st_q.div == DIV_LAST);
        unique case (st_q.state)
            CAL_IDLE: begin
                if (start) begin
                    st_d.state = CAL_SEARCH;
                    st_d.div = '0;
                    // low end unless a nearer start is asked for
                    st_d.code = use_start ? start_value : AMP_CODE_MIN;
                end
            end
            CAL_SEARCH: begin
                // detector only looked at after a full dwell
                if (tick) begin
                    st_d.div = '0;
                    if (at_target || (st_q.code >= AMP_CODE_MAX)) begin
                        st_d.state = CAL_IDLE;
                        st_d.done = 1'b1;
                    end else begin
                        st_d.code = st_q.code + 9'h001;
                    end
                end else begin
                    st_d.div = st_q.div + 16'h0001;
                end
            end
            default: begin
                st_d.state = CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy = (st_q.state == CAL_SEARCH);
    assign done = st_q.done;
    assign code = st_q.code;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_search_start;
        @(posedge aclk) disable iff (!aresetn)
        (st_q.state == CAL_IDLE) && start
        |=> (code == ($past(use_start) ? $past(start_value) : AMP_CODE_MIN));
    endproperty
    a_search_start: assert property (p_search_start)
        else $error("search did not begin at the chosen start code");

    property p_search_step;
        @(posedge aclk) disable iff (!aresetn)
        busy && tick && !at_target && (code < AMP_CODE_MAX)
        |=> busy && (code == $past(code) + 9'h001);
    endproperty
    a_search_step: assert property (p_search_step)
        else $error("search step did not advance the code by one");
endmodule : amplitude_cal_search
`default_nettype wire

// ==== rtl/pump_amp_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module pump_amp_regs #(
    parameter int unsigned STEP_CYCLES = synth_cal_pkg::CAL_STEP_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [synth_cal_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [synth_cal_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic amp_at_target,
    output logic [synth_cal_pkg::PUMP_CUR_W-1:0] pump_down_current,
    output logic [synth_cal_pkg::PUMP_CUR_W-1:0] pump_up_current,
    output logic [synth_cal_pkg::GAIN_W-1:0] pump_coarse_gain,
    output logic [2:0] pump_gain_halves,
    output logic [synth_cal_pkg::AMP_W-1:0] oscillator_amplitude_code,
    output logic amp_cal_busy
);
    import synth_cal_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic aw_full;
        logic [IDX_W-1:0] aw_idx;
        logic w_full;
        logic [REG_W-1:0] w_data;
        logic [1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [REG_W-1:0] pump_reg;
        logic [REG_W-1:0] amp_reg;
        logic [REG_W-1:0] start_reg;
        logic ovr;
        logic cal_en;
        logic use_start;
        logic go;
        logic cal_done_seen;
        logic [2:0] gain_halves;
        logic [AMP_W-1:0] osc_amp;
    } regs_s;

    localparam regs_s ST_RST = '{
        aw_full: 1'b0,
        aw_idx: '0,
        w_full: 1'b0,
        w_data: '0,
        w_strb: '0,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        rvalid: 1'b0,
        rdata: '0,
        rresp: RESP_OKAY,
        pump_reg: PUMP_REG_RST,
        amp_reg: AMP_REG_RST,
        start_reg: START_REG_RST,
        ovr: 1'b0,
        cal_en: 1'b1,
        use_start: 1'b0,
        go: 1'b0,
        cal_done_seen: 1'b0,
        gain_halves: GAIN_X2_HALVES,
        osc_amp: AMP_CODE_RST
    };

    regs_s st_q;
    regs_s st_d;
    logic cal_busy;
    logic cal_done;
    logic [AMP_W-1:0] cal_code;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic commit;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [REG_W-1:0] merge(
        input logic [REG_W-1:0] old_v,
        input logic [REG_W-1:0] new_v,
        input logic [1:0] strb
    );
        logic [REG_W-1:0] res;
        res = old_v;
        if (strb[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (strb[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction : merge

    function automatic logic [2:0] gain_of(input logic [GAIN_W-1:0] g);
        logic [2:0] h;
        h = GAIN_X1_HALVES;
        unique case (g)
            GAIN_CODE_X1: h = GAIN_X1_HALVES;
            GAIN_CODE_X2: h = GAIN_X2_HALVES;
            GAIN_CODE_X15: h = GAIN_X15_HALVES;
            GAIN_CODE_X25: h = GAIN_X25_HALVES;
        endcase
        return h;
    endfunction : gain_of

    // ------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------
    assign s_axi_awready = !st_q.aw_full;
    assign s_axi_wready = !st_q.w_full;
    assign s_axi_arready = !st_q.rvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign commit = st_q.aw_full && st_q.w_full && !st_q.bvalid;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.go = 1'b0;
        if (s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        // write: address and data held apart, either may come first
        if (commit) begin
            st_d.aw_full = 1'b0;
            st_d.w_full = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = RESP_OKAY;
            unique case (st_q.aw_idx)
                IDX_PUMP: begin
                    // every bit stored as written, no decode of currents
                    st_d.pump_reg = merge(st_q.pump_reg, st_q.w_data, st_q.w_strb);
                end
                IDX_AMP: begin
                    st_d.amp_reg = merge(st_q.amp_reg, st_q.w_data, st_q.w_strb);
                end
                IDX_START: begin
                    st_d.start_reg = merge(st_q.start_reg, st_q.w_data, st_q.w_strb);
                end
                IDX_CTRL: begin
                    if (st_q.w_strb[0]) begin
                        st_d.ovr = st_q.w_data[CTRL_OVR_BIT];
                        st_d.cal_en = st_q.w_data[CTRL_EN_BIT];
                        st_d.use_start = st_q.w_data[CTRL_USE_START_BIT];
                        // no new search started while overridden or disabled
                        st_d.go = st_q.w_data[CTRL_GO_BIT] && st_q.w_data[CTRL_EN_BIT]
                            && !st_q.w_data[CTRL_OVR_BIT];
                    end
                end
                IDX_STATUS: begin
                    st_d.bresp = RESP_OKAY;
                end
                default: begin
                    st_d.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (aw_take) begin
            st_d.aw_full = 1'b1;
            st_d.aw_idx = s_axi_awaddr[ADDR_W-1:2];
        end
        if (w_take) begin
            st_d.w_full = 1'b1;
            st_d.w_data = s_axi_wdata[REG_W-1:0];
            st_d.w_strb = s_axi_wstrb[1:0];
        end
        // read
        if (ar_take) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = RESP_OKAY;
            st_d.rdata = '0;
            unique case (s_axi_araddr[ADDR_W-1:2])
                IDX_PUMP: st_d.rdata[REG_W-1:0] = st_q.pump_reg;
                IDX_AMP: st_d.rdata[REG_W-1:0] = st_q.amp_reg;
                IDX_START: st_d.rdata[REG_W-1:0] = st_q.start_reg;
                IDX_CTRL: begin
                    st_d.rdata[CTRL_OVR_BIT] = st_q.ovr;
                    st_d.rdata[CTRL_EN_BIT] = st_q.cal_en;
                    st_d.rdata[CTRL_USE_START_BIT] = st_q.use_start;
                end
                IDX_STATUS: begin
                    st_d.rdata[STAT_BUSY_BIT] = cal_busy;
                    st_d.rdata[STAT_DONE_BIT] = st_q.cal_done_seen;
                    st_d.rdata[STAT_AMP_LSB +: AMP_W] = st_q.osc_amp;
                end
                default: begin
                    st_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        // calibration result lands after any bus write, so it wins
        if (st_q.go) begin
            st_d.cal_done_seen = 1'b0;
        end
        if (cal_done) begin
            st_d.amp_reg[AMP_CODE_LSB +: AMP_W] = cal_code;
            st_d.cal_done_seen = 1'b1;
        end
        st_d.gain_halves = gain_of(st_d.pump_reg[PUMP_GAIN_LSB +: GAIN_W]);
        // override feeds the amplitude field to the oscillator; a search already running still loads its result there
        st_d.osc_amp = st_d.ovr ? st_d.amp_reg[AMP_CODE_LSB +: AMP_W] : cal_code;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // calibration search
    // ------------------------------------------------------------
    amplitude_cal_search #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_search (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(st_q.go),
        .use_start(st_q.use_start),
        .start_value(st_q.start_reg[START_LSB +: AMP_W]),
        .at_target(amp_at_target),
        .busy(cal_busy),
        .done(cal_done),
        .code(cal_code)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign pump_down_current = st_q.pump_reg[PUMP_DN_LSB +: PUMP_CUR_W];
    assign pump_up_current = st_q.pump_reg[PUMP_UP_LSB +: PUMP_CUR_W];
    assign pump_coarse_gain = st_q.pump_reg[PUMP_GAIN_LSB +: GAIN_W];
    assign pump_gain_halves = st_q.gain_halves;
    assign oscillator_amplitude_code = st_q.osc_amp;
    assign amp_cal_busy = cal_busy;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_pump_reset;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> (pump_down_current == PUMP_CUR_RST)
            && (pump_up_current == PUMP_CUR_RST) && (pump_coarse_gain == GAIN_RST);
    endproperty
    a_pump_reset: assert property (p_pump_reset)
        else $error("pump fields not at reset value");

    property p_gain_scale;
        @(posedge aclk) disable iff (!aresetn)
        (pump_coarse_gain == GAIN_CODE_X25) |-> (pump_gain_halves == GAIN_X25_HALVES);
    endproperty
    a_gain_scale: assert property (p_gain_scale)
        else $error("coarse gain code 3 not scaled by 2.5");

    property p_gain_x2;
        @(posedge aclk) disable iff (!aresetn)
        (pump_coarse_gain == GAIN_CODE_X2) |-> (pump_gain_halves == GAIN_X2_HALVES);
    endproperty
    a_gain_x2: assert property (p_gain_x2)
        else $error("coarse gain code 1 not scaled by 2");

    property p_amp_reset;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> (st_q.amp_reg[AMP_CODE_LSB +: AMP_W] == AMP_CODE_RST);
    endproperty
    a_amp_reset: assert property (p_amp_reset)
        else $error("amplitude code not 300 after reset");

    property p_override;
        @(posedge aclk) disable iff (!aresetn)
        st_q.ovr |-> (oscillator_amplitude_code == st_q.amp_reg[AMP_CODE_LSB +: AMP_W]);
    endproperty
    a_override: assert property (p_override)
        else $error("override set but oscillator not fed from field");

    property p_no_override;
        @(posedge aclk) disable iff (!aresetn)
        !st_q.ovr && !$rose(aresetn) |-> (oscillator_amplitude_code == $past(cal_code));
    endproperty
    a_no_override: assert property (p_no_override)
        else $error("override clear but oscillator not fed from search");

    property p_result_load;
        @(posedge aclk) disable iff (!aresetn)
        cal_done |=> (st_q.amp_reg[AMP_CODE_LSB +: AMP_W] == $past(cal_code))
            && st_q.cal_done_seen;
    endproperty
    a_result_load: assert property (p_result_load)
        else $error("search result not loaded into amplitude field");
endmodule : pump_amp_regs
`default_nettype wire

// ==== verification/tb_pump_amp_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_pump_amp_regs;
    import synth_cal_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int unsigned STEP = 4;
    typedef struct packed {logic [15:0] w; logic [4:0] dn; logic [4:0] up; logic [2:0] h;} row_s;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, amp_at_target = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, amp_cal_busy;
    logic [1:0] s_axi_bresp, s_axi_rresp, pump_coarse_gain, r;
    logic [31:0] s_axi_rdata, d;
    logic [4:0] pump_down_current, pump_up_current;
    logic [2:0] pump_gain_halves;
    logic [8:0] oscillator_amplitude_code, target = 9'h1ff;
    int error_cnt = 0, check_count = 0, c1, c2;
    // dn always equal to up, unnamed bits left at zero
    // gains 1 and 3 only to prove the decode, a real host keeps 0 or 2
    row_s rows [4] = '{'{16'h0ad4, 5'h15, 5'h15, 3'h2}, '{16'h0ffd, 5'h1f, 5'h1f, 3'h4},
        '{16'h0002, 5'h00, 5'h00, 3'h3}, '{16'h018f, 5'h03, 5'h03, 3'h5}};

    pump_amp_regs #(.STEP_CYCLES(STEP)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .amp_at_target,
        .pump_down_current, .pump_up_current, .pump_coarse_gain, .pump_gain_halves,
        .oscillator_amplitude_code, .amp_cal_busy);

    always #5 aclk = ~aclk;
    // stand-in amplitude detector, one cycle late like a real comparator
    always @(posedge aclk) amp_at_target <= (oscillator_amplitude_code >= target);

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // ready looked at on the falling edge, where it is settled for the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        logic ah, wh, bh;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        bh = 1'b0;
        while (!bh) begin
            @(negedge aclk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) s_axi_bready <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic ah, rh;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rh = 1'b0;
        while (!rh) begin
            @(negedge aclk);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) s_axi_rready <= 1'b0;
        end
    endtask : rd

    // start a search and count the cycles it stays busy
    task automatic cal(input logic [31:0] ctrl, output int n);
        int k;
        wr(8'hc0, ctrl, 4'h3);
        k = 0;
        while (amp_cal_busy !== 1'b1 && k < 10) begin
            @(negedge aclk);
            k++;
        end
        n = 0;
        while (amp_cal_busy === 1'b1 && n < 5000) begin
            @(negedge aclk);
            n++;
        end
    endtask : cal

    task automatic print_verdict;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        #300000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check("dn_rst", 32'(pump_down_current), 32'h3);
        check("up_rst", 32'(pump_up_current), 32'h3);
        check("gain_rst", 32'(pump_gain_halves), 32'h4);
        check("osc_rst", 32'(oscillator_amplitude_code), 32'd300);
        rd(8'h38);
        check("pump_reg_rst", d, 32'h018d);
        rd(8'h4c);
        check("amp_reg_rst", d, 32'h0960);
        foreach (rows[i]) begin
            wr(8'h38, 32'(rows[i].w), 4'h3);
            rd(8'h38);
            check("pump_reg", d, 32'(rows[i].w));
            check("dn", 32'(pump_down_current), 32'(rows[i].dn));
            check("up", 32'(pump_up_current), 32'(rows[i].up));
            check("gain", 32'(pump_coarse_gain), 32'(rows[i].w[1:0]));
            check("halves", 32'(pump_gain_halves), 32'(rows[i].h));
        end
        // unmapped place refused, nothing read back
        wr(8'h00, 32'hffff, 4'h3);
        check("bad_wr_resp", 32'(r), 32'h2);
        rd(8'h00);
        check("bad_rd", {d[29:0], r}, 32'h2);
        // low byte lane only: register bits above bit 7 survive
        wr(8'h4c, 32'h0, 4'h1);
        rd(8'h4c);
        check("amp_strb", d, 32'h0900);
        // default search from the low end, then from a start value
        target = 9'd270;
        cal(32'h0a, c1);
        check("osc_cal", 32'(oscillator_amplitude_code), 32'd270);
        rd(8'h4c);
        check("amp_loaded", d, 32'h0870);
        rd(8'hc4);
        check("status", d, 32'h10e2);
        wr(8'h50, 32'd265, 4'h3);
        cal(32'h0e, c2);
        check("start_faster", 32'(c2 < c1 && c2 > 0), 32'h1);
        rd(8'h4c);
        check("amp_loaded2", d, 32'h0870);
        // override: programmed code reaches the oscillator, go ignored
        wr(8'h4c, 32'h0c80, 4'h3);
        wr(8'hc0, 32'h09, 4'h3);
        repeat (3) @(posedge aclk);
        check("osc_ovr", 32'(oscillator_amplitude_code), 32'd400);
        check("busy_ovr", 32'(amp_cal_busy), 32'h0);
        // go reads back as zero, enable was written low
        rd(8'hc0);
        check("ctrl_rd", d, 32'h1);
        rd(8'h50);
        check("start_rd", d, 32'd265);
        // status is read-only: write accepted and ignored
        wr(8'hc4, 32'h0, 4'h3);
        check("status_wr_resp", 32'(r), 32'h0);
        // second reset in mid-run restores the defaults
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h4c);
        check("amp_rst2", d, 32'h0960);
        print_verdict();
    end
endmodule : tb_pump_amp_regs
`default_nettype wire
